// ### shared/mrpc_pkg.sv
// package: constants and carriers for the module reset and power control
package mrpc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // long-hold switch-off time in milliseconds
  localparam int unsigned OFF_HOLD_MS = 1800;
  localparam longint unsigned OFF_HOLD_CYC_L =
    (longint'(OFF_HOLD_MS) * longint'(CLK_HZ)) / 64'd1000;
  localparam int unsigned OFF_HOLD_CYC = int'(OFF_HOLD_CYC_L);
  localparam int unsigned CNT_W = 28;
  // least reset hold the host should apply, nanoseconds
  localparam int unsigned RST_HOLD_NS = 120000;
  localparam int unsigned NUM_PIO = 64;
  localparam logic [63:0] STRONG_PU_MASK = 64'h0000_0000_0000_480a;
  localparam logic [63:0] WEAK_PD_MASK = 64'h1000_0000_0001_0030;
  localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    MRPC_RUN = 2'b00,
    MRPC_RESET = 2'b01,
    MRPC_OFF = 2'b10
  } mrpc_state_t;

  // pull controls applied to the programmable pins
  typedef struct packed {
    logic [63:0] strong_pullup;
    logic [63:0] strong_pulldown;
    logic [63:0] weak_pullup;
    logic [63:0] weak_pulldown;
  } mrpc_pulls_t;

  // reset sources seen by the sequencer
  typedef struct packed {
    logic pin;
    logic por;
    logic charger;
    logic watchdog;
  } mrpc_src_t;
endpackage

// ### src/mrpc_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module mrpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### src/mrpc_top.sv
// reset and power sequencer of the wireless audio module
//
// Behaviour
// - reset on pin, power-on, charger, watchdog
// - external reset input is active low
// - in reset, pins inputs, outputs tristated
// - usb lines tristated, button pin unpulled
// - strong pull-up on pins 1,3,11,14
// - weak pull-down on pins 4,5,16,60
// - low over 1.8s without charger: off
// - wake from off on rising edge
// - shared pin is reset while off/booting
`timescale 1ns/10ps
`default_nettype none
module mrpc_top #(
  parameter int unsigned OFF_HOLD_CYC = mrpc_pkg::OFF_HOLD_CYC
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic RESET_IN_N,
  input wire logic POR_IN,
  input wire logic CHARGER_SUPPLY_IN,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic BUTTON_WAKE_PIN,
  input wire logic BOOT_DONE,
  input wire logic SHARED_PIN_AS_GPIO,
  output logic RESET_ACTIVE,
  output logic POWER_ON,
  output logic [63:0] PIO_OE_N,
  output logic [63:0] OUT_HIZ,
  output logic USB_OE_N,
  output logic BUTTON_PULL_EN,
  output var mrpc_pkg::mrpc_pulls_t PIN_PULLS,
  output logic SHARED_PIN_IS_RESET
);
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [4:0] raw_in;
  logic [4:0] sync_in;
  logic reset_in_n;
  logic por_s;
  logic chg_s;
  logic btn_s;
  logic wdog_s;

  assign raw_in = {RESET_IN_N, POR_IN, CHARGER_SUPPLY_IN,
                   BUTTON_WAKE_PIN, WATCHDOG_EXPIRED};

  // reset line idles high, so it leaves reset deasserted
  mrpc_sync #(.W(5), .RST_VAL(5'h10)) u_sync (
    .CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign reset_in_n = sync_in[4];
  assign por_s = sync_in[3];
  assign chg_s = sync_in[2];
  assign btn_s = sync_in[1];
  assign wdog_s = sync_in[0];

  // ----------------------------------------------------------------
  // edge detection and source gathering
  // ----------------------------------------------------------------
  logic chg_prev_q;
  logic btn_prev_q;
  logic chg_rise;
  logic btn_rise;
  logic pin_reset_req;
  mrpc_pkg::mrpc_src_t src;
  logic any_src;

  // history flops reset to the idle low level of both pins, so that
  // leaving reset shows no false rising edge
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      chg_prev_q <= 1'b0;
      btn_prev_q <= 1'b0;
    end else begin
      chg_prev_q <= chg_s;
      btn_prev_q <= btn_s;
    end
  end

  assign chg_rise = chg_s & ~chg_prev_q;
  assign btn_rise = btn_s & ~btn_prev_q;

  // state register, declared here as the handover logic reads it
  mrpc_pkg::mrpc_state_t state_q;
  mrpc_pkg::mrpc_state_t state_d;

  // the shared pin only stops acting as reset once software, after
  // boot, hands it over to general-purpose use
  logic gpio_mode_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      gpio_mode_q <= 1'b0;
    end else if (state_q != mrpc_pkg::MRPC_RUN) begin
      gpio_mode_q <= 1'b0;
    end else if (BOOT_DONE && SHARED_PIN_AS_GPIO) begin
      gpio_mode_q <= 1'b1;
    end
  end

  assign pin_reset_req = ~reset_in_n & ~gpio_mode_q;
  assign src.pin = pin_reset_req;
  assign src.por = por_s;
  assign src.charger = chg_rise;
  assign src.watchdog = wdog_s;
  assign any_src = |src;

  // ----------------------------------------------------------------
  // long-hold counter
  // ----------------------------------------------------------------
  logic [mrpc_pkg::CNT_W-1:0] hold_cnt_q;
  logic hold_expired;
  localparam logic [mrpc_pkg::CNT_W-1:0] HOLD_LIMIT =
    mrpc_pkg::CNT_W'(OFF_HOLD_CYC);

  // the count restarts whenever the line returns high, so only an
  // unbroken low interval can turn the module off
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      hold_cnt_q <= '0;
    end else if (!pin_reset_req) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != HOLD_LIMIT) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // qualified by the live request: the count clears one edge after the
  // line returns high, and a release must not switch off in that gap
  assign hold_expired = pin_reset_req && (hold_cnt_q == HOLD_LIMIT);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mrpc_pkg::MRPC_RUN: begin
        if (any_src) begin
          state_d = mrpc_pkg::MRPC_RESET;
        end
      end
      mrpc_pkg::MRPC_RESET: begin
        if (hold_expired && !chg_s) begin
          state_d = mrpc_pkg::MRPC_OFF;
        end else if (!any_src) begin
          state_d = mrpc_pkg::MRPC_RUN;
        end
      end
      mrpc_pkg::MRPC_OFF: begin
        if (btn_rise || chg_rise) begin
          state_d = mrpc_pkg::MRPC_RESET;
        end
      end
      default: state_d = mrpc_pkg::MRPC_RESET;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q <= mrpc_pkg::MRPC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // pin state outputs
  // ----------------------------------------------------------------
  logic safe_d;
  assign safe_d = (state_d != mrpc_pkg::MRPC_RUN);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RESET_ACTIVE <= 1'b1;
      POWER_ON <= 1'b1;
      SHARED_PIN_IS_RESET <= 1'b1;
    end else begin
      RESET_ACTIVE <= safe_d;
      POWER_ON <= (state_d != mrpc_pkg::MRPC_OFF);
      SHARED_PIN_IS_RESET <= safe_d | ~gpio_mode_q;
    end
  end

  // while in reset or off, drivers are released and reset pulls apply;
  // in run the core owns pads, so pulls and enables drop to defaults
  localparam mrpc_pkg::mrpc_pulls_t SAFE_PULLS = '{
    strong_pullup: mrpc_pkg::STRONG_PU_MASK,
    strong_pulldown: mrpc_pkg::ZERO64,
    weak_pullup: mrpc_pkg::ZERO64,
    weak_pulldown: mrpc_pkg::WEAK_PD_MASK
  };

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || safe_d) begin
      PIO_OE_N <= ~mrpc_pkg::ZERO64;
      OUT_HIZ <= ~mrpc_pkg::ZERO64;
      USB_OE_N <= 1'b1;
      BUTTON_PULL_EN <= 1'b0;
    end else begin
      PIO_OE_N <= ~mrpc_pkg::ZERO64;
      OUT_HIZ <= mrpc_pkg::ZERO64;
      USB_OE_N <= 1'b1;
      BUTTON_PULL_EN <= 1'b0;
    end
  end

  // pulls kept apart: only the reset pattern is ours, pulls in run are
  // left to software and stay at none here
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || safe_d) begin
      PIN_PULLS <= SAFE_PULLS;
    end else begin
      PIN_PULLS <= '0;
    end
  end
endmodule
`default_nettype wire

// ### tb/mrpc_assertions.sv
// port checker for the reset and power sequencer
`timescale 1ns/10ps
`default_nettype none
module mrpc_checker (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic RESET_IN_N,
  input wire logic POR_IN,
  input wire logic CHARGER_SUPPLY_IN,
  input wire logic RESET_ACTIVE,
  input wire logic POWER_ON,
  input wire logic [63:0] PIO_OE_N,
  input wire logic [63:0] OUT_HIZ,
  input wire logic USB_OE_N,
  input wire logic BUTTON_PULL_EN,
  input wire mrpc_pkg::mrpc_pulls_t PIN_PULLS,
  input wire logic SHARED_PIN_IS_RESET
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // four samples cover the two sync flops plus the output flop; a line
  // handed over to general-purpose use is no reset source
  a_pin_reset: assert property (
    (!RESET_IN_N && SHARED_PIN_IS_RESET) [*4] |-> RESET_ACTIVE)
    else $error("low reset line ignored");
  a_por_reset: assert property (POR_IN [*4] |-> RESET_ACTIVE)
    else $error("power-on source ignored");
  a_safe_pins: assert property (
    RESET_ACTIVE |-> &{PIO_OE_N, OUT_HIZ})
    else $error("pins not safe in reset");
  a_fixed_pins: assert property (USB_OE_N && !BUTTON_PULL_EN)
    else $error("usb driven or button pulled");
  a_strong_pu: assert property (RESET_ACTIVE && POWER_ON |->
    PIN_PULLS.strong_pullup == mrpc_pkg::STRONG_PU_MASK)
    else $error("strong pull-ups wrong");
  a_weak_pd: assert property (RESET_ACTIVE && POWER_ON |->
    PIN_PULLS.weak_pulldown == mrpc_pkg::WEAK_PD_MASK)
    else $error("weak pull-downs wrong");
  a_off_cause: assert property ($fell(POWER_ON) |->
    !$past(RESET_IN_N, 3) && !$past(CHARGER_SUPPLY_IN, 3))
    else $error("switched off without cause");
  a_off_held: assert property (
    !POWER_ON |-> RESET_ACTIVE && SHARED_PIN_IS_RESET)
    else $error("off but not held");
  c_gpio: cover property ($fell(SHARED_PIN_IS_RESET));
  c_off: cover property ($fell(POWER_ON));
  c_wake: cover property ($rose(POWER_ON));
  c_run: cover property ($fell(RESET_ACTIVE));
endmodule
bind mrpc_top mrpc_checker chk_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .RESET_IN_N(RESET_IN_N), .POR_IN(POR_IN), .POWER_ON(POWER_ON),
  .CHARGER_SUPPLY_IN(CHARGER_SUPPLY_IN), .RESET_ACTIVE(RESET_ACTIVE),
  .PIO_OE_N(PIO_OE_N), .OUT_HIZ(OUT_HIZ), .USB_OE_N(USB_OE_N),
  .BUTTON_PULL_EN(BUTTON_PULL_EN), .PIN_PULLS(PIN_PULLS),
  .SHARED_PIN_IS_RESET(SHARED_PIN_IS_RESET));
`default_nettype wire

// ### tb/mrpc_host.sv
// host board model driving the reset line and wake sources
`timescale 1ns/10ps
`default_nettype none
module mrpc_host #(
  // shortest low pulse the board gives on the reset line, in cycles
  parameter int MIN_LOW_CYC = mrpc_pkg::RST_HOLD_NS *
    (mrpc_pkg::CLK_HZ / 1000000) / 1000
) (
  input wire logic clk,
  output logic [4:0] pins
);
  int low_cyc_q = 0;
  // ----
  // stimulus
  // ----
  // order: reset line (active low), por, charger, watchdog, button
  initial pins = 5'h10;
  // reset line idles high, as it is active low
  // wake from off is given only as a rising step
  always @(posedge clk) begin
    low_cyc_q <= pins[4] ? 0 : low_cyc_q + 1;
  end
  task automatic drive(input logic [4:0] v);
    @(posedge clk);
    // a reset pulse is never cut short of the agreed hold
    while (!pins[4] && v[4] && low_cyc_q < MIN_LOW_CYC) @(posedge clk);
    #1 pins = v;
  endtask
endmodule
`default_nettype wire

// ### tb/mrpc_top_test.sv
// self-checking bench for the reset and power sequencer
`timescale 1ns/10ps
`default_nettype none
module mrpc_top_test;
  localparam int HOLD = 50;
  // reset pulses shortened along with the shortened switch-off time
  localparam int MIN_LOW = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot = 1'b0;
  logic gpio_req = 1'b0;
  logic ract, pon, shr;
  logic [4:0] p;
  logic [1:0] fix;
  logic [63:0] oe_n, hiz;
  mrpc_pkg::mrpc_pulls_t pl;
  int fail_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  mrpc_host #(.MIN_LOW_CYC(MIN_LOW)) host (.clk(clk), .pins(p));
  mrpc_top #(.OFF_HOLD_CYC(HOLD)) uut (.CORE_CLK(clk), .SYS_RST(rst),
    .RESET_IN_N(p[4]), .POR_IN(p[3]), .CHARGER_SUPPLY_IN(p[2]),
    .WATCHDOG_EXPIRED(p[1]), .BUTTON_WAKE_PIN(p[0]), .BOOT_DONE(boot),
    .SHARED_PIN_AS_GPIO(gpio_req), .RESET_ACTIVE(ract), .POWER_ON(pon),
    .PIO_OE_N(oe_n), .OUT_HIZ(hiz), .USB_OE_N(fix[1]),
    .BUTTON_PULL_EN(fix[0]), .PIN_PULLS(pl), .SHARED_PIN_IS_RESET(shr));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h", $time, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic to_run();
    for (int i = 0; i < 30 && ract !== 1'b0; i++) cyc(1);
  endtask
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_boot();
    to_run();
    chk({ract, shr}, 2'b01);
    boot = 1'b1;
    cyc(3);
    chk(shr, 1'b1);
    gpio_req = 1'b1;
    cyc(3);
    chk(shr, 1'b0);
    host.drive(5'h00);
    cyc(5);
    chk({ract, shr, pon}, 3'b001);
    gpio_req = 1'b0;
    host.drive(5'h18);
    cyc(3);
    chk({ract, shr}, 2'b11);
    host.drive(5'h10);
    to_run();
    chk({ract, shr}, 2'b01);
    $display("test boot done");
  endtask
  task automatic t_src();
    logic [4:0] v [4] = '{5'h00, 5'h18, 5'h14, 5'h12};
    foreach (v[i]) begin
      host.drive(v[i]);
      cyc(3);
      chk(ract, 1'b1);
      chk({oe_n, hiz}, {128{1'b1}});
      chk(fix, 2'b10);
      chk(pl, {mrpc_pkg::STRONG_PU_MASK, 128'h0,
        mrpc_pkg::WEAK_PD_MASK});
      chk(shr, 1'b1);
      host.drive(5'h10);
      to_run();
      chk(hiz, 64'h0);
    end
    $display("test sources done");
  endtask
  task automatic t_off();
    logic [4:0] w [2] = '{5'h11, 5'h14};
    foreach (w[i]) begin
      host.drive(5'h00);
      cyc(HOLD + 10);
      chk(pon, 1'b0);
      host.drive(5'h10);
      cyc(10);
      chk({pon, ract, shr}, 3'b011);
      host.drive(w[i]);
      cyc(4);
      chk(pon, 1'b1);
      host.drive(5'h10);
      to_run();
      chk(ract, 1'b0);
    end
    $display("test off done");
  endtask
  task automatic t_hold();
    host.drive(5'h00);
    cyc(HOLD - 10);
    host.drive(5'h10);
    cyc(3);
    host.drive(5'h00);
    cyc(HOLD - 10);
    chk(pon, 1'b1);
    host.drive(5'h14);
    host.drive(5'h04);
    cyc(HOLD + 10);
    chk(pon, 1'b1);
    host.drive(5'h10);
    to_run();
    chk(ract, 1'b0);
    $display("test hold done");
  endtask
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
  initial begin
    cyc(5);
    rst = 1'b0;
    t_boot();
    t_src();
    t_off();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire
